// file: hw/req_decode_pkg.sv
// Constants and carrier types for the request opcode decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package req_decode_pkg;
    localparam int PKT_W = 24;
    localparam int PIN_W = 12;
    localparam int ROW_W = 12;
    localparam int BANK_W = 3;
    localparam int DLY_W = 2;
    localparam int CLK_PERIOD_NS = 5;
    localparam int LINK_PERIOD_NS = 160;
    localparam int DLY_SLOTS = 4;

    localparam logic [3:0] SEL_IDLE = 4'h0;
    localparam logic [3:0] SEL_COLUMN = 4'h1;
    localparam logic [3:0] SEL_EXTENDED = 4'h2;
    localparam logic [3:0] SEL_CLOSE_REFRESH = 4'h3;

    localparam logic [2:0] REF_IDLE = 3'h0;
    localparam logic [2:0] REF_CLOSE = 3'h1;
    localparam logic [2:0] REF_OPEN = 3'h2;
    localparam logic [2:0] REF_OPEN_INC = 3'h3;
    localparam logic [2:0] REF_LOAD_LOW = 3'h4;
    localparam logic [2:0] REF_LOAD_MID = 3'h5;

    localparam logic [3:0] XOP_CURRENT_TRIM = 4'h8;
    localparam logic [3:0] XOP_IMPEDANCE_TRIM = 4'h9;
    localparam logic [3:0] XOP_TRIM_END = 4'ha;
    localparam logic [3:0] XOP_POWER_DOWN = 4'hc;

    localparam logic [ROW_W-1:0] REFRESH_ROW_RESET = 12'h000;

    // Field positions inside the assembled 24-bit packet
    localparam int SEL_HI = 23;
    localparam int SEL_LO = 20;
    localparam int DIR_BIT = 19;
    localparam int CPOST_BIT = 18;
    localparam int APOST_BIT = 18;
    localparam int BANK_HI = 17;
    localparam int BANK_LO = 15;
    localparam int ROW_HI = 11;
    localparam int ROW_LO = 0;
    localparam int COL_HI = 9;
    localparam int COL_LO = 0;
    localparam int MASK_HI = 17;
    localparam int MASK_LO = 10;
    localparam int MBANK_HI = 19;
    localparam int MBANK_LO = 17;
    localparam int POP_HI = 19;
    localparam int POP_LO = 17;
    localparam int PBANK_HI = 16;
    localparam int PBANK_LO = 14;
    localparam int ROP_HI = 13;
    localparam int ROP_LO = 11;
    localparam int RA_HI = 7;
    localparam int RA_LO = 0;
    localparam int XOP_HI = 3;
    localparam int XOP_LO = 0;

    typedef struct packed {
        logic [BANK_W-1:0] bank;
        logic [ROW_W-1:0] addr;
        logic [7:0] mask;
    } mem_cmd_t;

    typedef struct packed {
        logic current_trim;
        logic impedance_trim;
        logic trim_end;
        logic power_down_entry;
    } maint_cmd_t;
endpackage : req_decode_pkg

// file: hw/link_sampler.sv
`timescale 1ns/1ps
// Samples the request pins on both edges of the request clock.
// Assumes link clock and pins are asynchronous to clock.
module link_sampler
    import req_decode_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic [PIN_W-1:0] request_pins,
    output logic [PKT_W-1:0] packet_reg,
    output logic packet_valid_reg
);
    logic [3:0] clk_sync_reg;
    logic [PIN_W-1:0] pin_sync1_reg;
    logic [PIN_W-1:0] pin_sync2_reg;
    logic [PIN_W-1:0] first_half_reg;
    logic have_first_reg;
    // Edges are seen one stage late so the pins have settled a full cycle
    wire rise = clk_sync_reg[2] & ~clk_sync_reg[3];
    wire fall = ~clk_sync_reg[2] & clk_sync_reg[3];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            clk_sync_reg <= 4'h0;
            pin_sync1_reg <= '0;
            pin_sync2_reg <= '0;
        end else begin
            clk_sync_reg <= {clk_sync_reg[2:0], link_clk};
            pin_sync1_reg <= request_pins;
            pin_sync2_reg <= pin_sync1_reg;
        end
    end

    // First half on rising edge, second half on following falling edge
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            first_half_reg <= '0;
            have_first_reg <= 1'b0;
            packet_reg <= '0;
            packet_valid_reg <= 1'b0;
        end else begin
            packet_valid_reg <= 1'b0;
            if (rise) begin
                first_half_reg <= pin_sync2_reg;
                have_first_reg <= 1'b1;
            end else if (fall && have_first_reg) begin
                packet_reg <= {first_half_reg, pin_sync2_reg};
                packet_valid_reg <= 1'b1;
                have_first_reg <= 1'b0;
            end
        end
    end
endmodule : link_sampler

// file: hw/postpone_line.sv
`timescale 1ns/1ps
// Delay line of command strobes with 0..DLY_SLOTS-1 cycle postponement.
// Assumes one command enters at a time per instance.
module postpone_line
    import req_decode_pkg::*;
#(
    parameter int W = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic in_valid,
    input wire logic [DLY_W-1:0] in_delay,
    input wire logic [W-1:0] in_data,
    output logic out_valid_reg,
    output logic [W-1:0] out_data_reg
);
    logic [DLY_SLOTS-1:0] v_reg;
    logic [W-1:0] d_reg [DLY_SLOTS];

    genvar i;
    generate
        for (i = 0; i < DLY_SLOTS; i++) begin : g_slot
            wire load = in_valid && (in_delay == DLY_W'(i));
            if (i == DLY_SLOTS - 1) begin : g_top
                always_ff @(posedge clock or negedge resetn) begin
                    if (!resetn) begin
                        v_reg[i] <= 1'b0;
                        d_reg[i] <= '0;
                    end else begin
                        v_reg[i] <= load;
                        d_reg[i] <= in_data;
                    end
                end
            end else begin : g_mid
                always_ff @(posedge clock or negedge resetn) begin
                    if (!resetn) begin
                        v_reg[i] <= 1'b0;
                        d_reg[i] <= '0;
                    end else begin
                        v_reg[i] <= load | v_reg[i+1];
                        d_reg[i] <= load ? in_data : d_reg[i+1];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out_valid_reg <= 1'b0;
            out_data_reg <= '0;
        end else begin
            out_valid_reg <= v_reg[0];
            out_data_reg <= d_reg[0];
        end
    end
endmodule : postpone_line

// file: hw/dram_request_opcode_decoder.sv
`timescale 1ns/1ps
// Request packet opcode decoder: turns request packets into core strobes.
// Assumes request pins and link clock come from outside the clock domain.
module dram_request_opcode_decoder
    import req_decode_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic [PIN_W-1:0] request_pins,
    output logic col_read_reg,
    output logic col_write_reg,
    output logic masked_store_reg,
    output mem_cmd_t col_cmd_reg,
    output logic row_open_reg,
    output mem_cmd_t open_cmd_reg,
    output logic bank_close_reg,
    output logic [BANK_W-1:0] close_bank_reg,
    output logic refresh_close_reg,
    output logic [BANK_W-1:0] refresh_close_bank_reg,
    output logic refresh_open_reg,
    output mem_cmd_t refresh_open_cmd_reg,
    output maint_cmd_t maint_reg,
    output logic [ROW_W-1:0] refresh_row_set
);
    logic [PKT_W-1:0] pkt;
    logic pkt_valid;

    link_sampler i_link_sampler (
        .clock(clock),
        .resetn(resetn),
        .link_clk(link_clk),
        .request_pins(request_pins),
        .packet_reg(pkt),
        .packet_valid_reg(pkt_valid)
    );

    // Packet type decode
    wire [3:0] packet_selector_code = pkt[SEL_HI:SEL_LO];
    wire is_idle = packet_selector_code == SEL_IDLE;
    wire is_column = pkt_valid && packet_selector_code == SEL_COLUMN;
    wire is_extended = pkt_valid && packet_selector_code == SEL_EXTENDED;
    wire is_close_ref = pkt_valid
        && packet_selector_code == SEL_CLOSE_REFRESH;
    wire is_open = pkt_valid && packet_selector_code[3:2] == 2'b01;
    wire is_masked = pkt_valid && packet_selector_code[3];

    // Column, masked and row open access fields
    wire column_dir_bit = pkt[DIR_BIT];
    wire column_postpone = pkt[CPOST_BIT];
    wire activate_postpone = pkt[APOST_BIT];
    wire [BANK_W-1:0] column_target_sel = pkt[BANK_HI:BANK_LO];
    wire [BANK_W-1:0] masked_target_sel = pkt[MBANK_HI:MBANK_LO];
    wire [BANK_W-1:0] activate_target_sel = pkt[BANK_HI:BANK_LO];
    wire [7:0] byte_mask_field = pkt[MASK_HI:MASK_LO];
    wire [ROW_W-1:0] col_addr = {2'b00, pkt[COL_HI:COL_LO]};
    wire [ROW_W-1:0] row_addr = pkt[ROW_HI:ROW_LO];

    // Close-and-refresh fields
    wire [2:0] close_subcode = pkt[POP_HI:POP_LO];
    wire [BANK_W-1:0] close_target_sel = pkt[PBANK_HI:PBANK_LO];
    wire [2:0] refresh_subcode = pkt[ROP_HI:ROP_LO];
    wire [7:0] refresh_field = pkt[RA_HI:RA_LO];
    wire [BANK_W-1:0] refresh_target_sel = refresh_field[2:0];
    wire [DLY_W-1:0] refresh_delay = refresh_field[7:6];
    wire close_go = is_close_ref && close_subcode[2];
    wire ref_close_go = is_close_ref
        && refresh_subcode == REF_CLOSE;
    wire ref_open_go = is_close_ref && (refresh_subcode == REF_OPEN
        || refresh_subcode == REF_OPEN_INC);
    wire ref_inc = is_close_ref && refresh_subcode == REF_OPEN_INC;
    wire load_low = is_close_ref
        && refresh_subcode == REF_LOAD_LOW;
    wire load_mid = is_close_ref
        && refresh_subcode == REF_LOAD_MID;

    // Extended subcode decode
    wire [3:0] extended_subcode = pkt[XOP_HI:XOP_LO];
    maint_cmd_t maint_next;
    assign maint_next.current_trim = is_extended
        && extended_subcode == XOP_CURRENT_TRIM;
    assign maint_next.impedance_trim = is_extended
        && extended_subcode == XOP_IMPEDANCE_TRIM;
    assign maint_next.trim_end = is_extended
        && extended_subcode == XOP_TRIM_END;
    assign maint_next.power_down_entry = is_extended
        && extended_subcode == XOP_POWER_DOWN;

    // Column access entry: read/write, or masked store with no delay
    localparam int CW = 2 + $bits(mem_cmd_t);
    mem_cmd_t col_in;
    assign col_in.bank = is_masked ? masked_target_sel : column_target_sel;
    assign col_in.addr = col_addr;
    assign col_in.mask = is_masked ? byte_mask_field : 8'hff;
    wire col_go = is_column || is_masked;
    wire [DLY_W-1:0] col_delay = is_masked ? 2'h0
        : {1'b0, column_postpone};
    wire [1:0] col_kind = is_masked ? 2'h2 : {1'b0, column_dir_bit};
    logic col_out_v;
    logic [CW-1:0] col_out;

    postpone_line #(.W(CW)) u_col (
        .clock(clock),
        .resetn(resetn),
        .in_valid(col_go),
        .in_delay(col_delay),
        .in_data({col_kind, col_in}),
        .out_valid_reg(col_out_v),
        .out_data_reg(col_out)
    );

    // Row open entry
    mem_cmd_t open_in;
    assign open_in.bank = activate_target_sel;
    assign open_in.addr = row_addr;
    assign open_in.mask = 8'h00;
    logic open_out_v;
    mem_cmd_t open_out;

    postpone_line #(.W($bits(mem_cmd_t))) u_open (
        .clock(clock),
        .resetn(resetn),
        .in_valid(is_open),
        .in_delay({1'b0, activate_postpone}),
        .in_data(open_in),
        .out_valid_reg(open_out_v),
        .out_data_reg(open_out)
    );

    // Precharge entry
    logic close_out_v;
    logic [BANK_W-1:0] close_out;

    postpone_line #(.W(BANK_W)) u_close (
        .clock(clock),
        .resetn(resetn),
        .in_valid(close_go),
        .in_delay(close_subcode[1:0]),
        .in_data(close_target_sel),
        .out_valid_reg(close_out_v),
        .out_data_reg(close_out)
    );

    // Refresh entry; the held row is captured at issue, the increment
    // lands once the open strobe leaves the delay line
    logic refresh_out_v;
    logic [BANK_W+ROW_W+1:0] refresh_out;
    logic [ROW_W-1:0] row_hold_reg;

    postpone_line #(.W(BANK_W + ROW_W + 2)) u_refresh (
        .clock(clock),
        .resetn(resetn),
        .in_valid(ref_close_go || ref_open_go),
        .in_delay(refresh_delay),
        .in_data({ref_open_go, ref_inc, refresh_target_sel, row_hold_reg}),
        .out_valid_reg(refresh_out_v),
        .out_data_reg(refresh_out)
    );

    wire ref_out_open = refresh_out[BANK_W+ROW_W+1];
    wire ref_out_inc = refresh_out[BANK_W+ROW_W];
    wire [BANK_W-1:0] ref_out_bank = refresh_out[BANK_W+ROW_W-1:ROW_W];
    wire [ROW_W-1:0] ref_out_row = refresh_out[ROW_W-1:0];
    wire inc_now = refresh_out_v && ref_out_open && ref_out_inc;

    // Refresh row value: 12 bits only, loads and increment
    logic [ROW_W-1:0] row_hold_next;
    always_comb begin
        row_hold_next = row_hold_reg;
        if (inc_now)
            row_hold_next = row_hold_reg + 12'h001;
        if (load_low)
            row_hold_next[7:0] = refresh_field;
        else if (load_mid)
            row_hold_next[11:8] = refresh_field[3:0];
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn)
            row_hold_reg <= REFRESH_ROW_RESET;
        else
            row_hold_reg <= row_hold_next;
    end

    // Output registers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            col_read_reg <= 1'b0;
            col_write_reg <= 1'b0;
            masked_store_reg <= 1'b0;
            col_cmd_reg <= '0;
            row_open_reg <= 1'b0;
            open_cmd_reg <= '0;
            bank_close_reg <= 1'b0;
            close_bank_reg <= '0;
            refresh_close_reg <= 1'b0;
            refresh_close_bank_reg <= '0;
            refresh_open_reg <= 1'b0;
            refresh_open_cmd_reg <= '0;
            maint_reg <= '0;
            refresh_row_set <= REFRESH_ROW_RESET;
        end else begin
            col_read_reg <= col_out_v && col_out[CW-1:CW-2] == 2'h0;
            col_write_reg <= col_out_v && col_out[CW-1:CW-2] == 2'h1;
            masked_store_reg <= col_out_v && col_out[CW-1];
            col_cmd_reg <= col_out[CW-3:0];
            row_open_reg <= open_out_v;
            open_cmd_reg <= open_out;
            bank_close_reg <= close_out_v;
            close_bank_reg <= close_out;
            refresh_close_reg <= refresh_out_v && !ref_out_open;
            refresh_close_bank_reg <= ref_out_bank;
            refresh_open_reg <= refresh_out_v && ref_out_open;
            refresh_open_cmd_reg <= '{bank: ref_out_bank,
                addr: ref_out_row, mask: 8'h00};
            maint_reg <= maint_next;
            refresh_row_set <= row_hold_next;
        end
    end

    // Checks
    logic any_strobe;
    assign any_strobe = col_read_reg || col_write_reg || masked_store_reg
        || row_open_reg || bank_close_reg || refresh_close_reg
        || refresh_open_reg || (|maint_reg);

    a_idle_quiet: assert property (@(posedge clock) disable iff (!resetn)
        pkt_valid && is_idle |=> (!any_strobe) [*6])
        else $error("idle packet started an operation");

    sequence s_read_req;
        is_column && !column_dir_bit && !column_postpone;
    endsequence
    a_read_nodelay: assert property (@(posedge clock) disable iff (!resetn)
        s_read_req |-> ##3 col_read_reg)
        else $error("column read strobe late or missing");

    a_write_delay: assert property (@(posedge clock) disable iff (!resetn)
        is_column && column_dir_bit && column_postpone
        |-> ##4 col_write_reg)
        else $error("postponed write strobe not at four cycles");

    a_power_down: assert property (@(posedge clock) disable iff (!resetn)
        is_extended && extended_subcode == XOP_POWER_DOWN
        |=> maint_reg.power_down_entry)
        else $error("power-down entry not raised");

    a_trim_decode: assert property (@(posedge clock) disable iff (!resetn)
        maint_reg.current_trim |-> !maint_reg.trim_end
        && $past(extended_subcode) == XOP_CURRENT_TRIM)
        else $error("trim decode mismatch");

    a_close_delay: assert property (@(posedge clock) disable iff (!resetn)
        close_go && close_subcode[1:0] == 2'h3
        |-> ##6 bank_close_reg)
        else $error("precharge delay three not honoured");

    a_close_none: assert property (@(posedge clock) disable iff (!resetn)
        is_close_ref && !close_subcode[2]
        |=> (!bank_close_reg) [*6])
        else $error("precharge without a close command");

    a_load_low: assert property (@(posedge clock) disable iff (!resetn)
        load_low |=> row_hold_reg[7:0] == $past(refresh_field))
        else $error("low row load lost");

    a_load_mid: assert property (@(posedge clock) disable iff (!resetn)
        load_mid |=> row_hold_reg[11:8] == $past(refresh_field[3:0]))
        else $error("middle row load lost");

    a_row_incr: assert property (@(posedge clock) disable iff (!resetn)
        inc_now && !load_low && !load_mid
        |=> row_hold_reg == $past(row_hold_reg) + 12'h001)
        else $error("held row not incremented");
endmodule : dram_request_opcode_decoder

// file: test/req_controller_model.sv
`timescale 1ns/1ps
// Request controller model: drives link clock and request pins.
// Assumes the bench calls send once per packet and waits for its return.
module req_controller_model
    import req_decode_pkg::*;
#(
    parameter int HALF = 16
) (
    input wire logic clock,
    output logic link_clk,
    output logic [PIN_W-1:0] request_pins
);
    initial begin
        link_clk = 1'b0;
        request_pins = 12'h000;
    end

    // Link clock stands low between packets; released pins show the
    // inverse of their last value so stale bits never pass as data.
    // One packet takes two half periods, far above load spacing.
    task automatic send(input logic [PKT_W-1:0] pkt);
        @(negedge clock);
        request_pins = pkt[23:12];
        link_clk = 1'b1;
        repeat (HALF) @(negedge clock);
        request_pins = pkt[11:0];
        link_clk = 1'b0;
        repeat (HALF) @(negedge clock);
        request_pins = ~pkt[11:0];
    endtask : send
endmodule : req_controller_model

// file: test/test_dram_request_opcode_decoder.sv
`timescale 1ns/1ps
// Self-checking bench for the request opcode decoder.
// Assumes the controller model drives the link; outputs seen at negedge.
module test_dram_request_opcode_decoder;
    import req_decode_pkg::*;
    localparam logic [10:0] S_RD = 11'h400;
    localparam logic [10:0] S_WR = 11'h200;
    localparam logic [10:0] S_WM = 11'h100;
    localparam logic [10:0] S_ACT = 11'h080;
    localparam logic [10:0] S_PRE = 11'h040;
    localparam logic [10:0] S_RCL = 11'h020;
    localparam logic [10:0] S_ROP = 11'h010;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic link_clk;
    logic [PIN_W-1:0] request_pins;
    logic col_read_reg, col_write_reg, masked_store_reg, row_open_reg;
    logic bank_close_reg, refresh_close_reg, refresh_open_reg;
    mem_cmd_t col_cmd_reg, open_cmd_reg, refresh_open_cmd_reg;
    mem_cmd_t ccap, ocap, rcap;
    logic [BANK_W-1:0] close_bank_reg, refresh_close_bank_reg, pcap, fcap;
    maint_cmd_t maint_reg;
    logic [ROW_W-1:0] refresh_row_set;
    logic [10:0] strb, seen, dbl;
    int lat [11];
    int error_cnt = 0;
    int n_tests = 0;
    int b;

    assign strb = {col_read_reg, col_write_reg, masked_store_reg,
        row_open_reg, bank_close_reg, refresh_close_reg, refresh_open_reg,
        maint_reg};

    always #2.5 clock = ~clock;

    req_controller_model i_req_controller_model (
        .clock(clock), .link_clk(link_clk), .request_pins(request_pins));

    dram_request_opcode_decoder i_dram_request_opcode_decoder (
        .clock(clock), .resetn(resetn), .link_clk(link_clk),
        .request_pins(request_pins), .col_read_reg(col_read_reg),
        .col_write_reg(col_write_reg), .masked_store_reg(masked_store_reg),
        .col_cmd_reg(col_cmd_reg), .row_open_reg(row_open_reg),
        .open_cmd_reg(open_cmd_reg), .bank_close_reg(bank_close_reg),
        .close_bank_reg(close_bank_reg),
        .refresh_close_reg(refresh_close_reg),
        .refresh_close_bank_reg(refresh_close_bank_reg),
        .refresh_open_reg(refresh_open_reg),
        .refresh_open_cmd_reg(refresh_open_cmd_reg),
        .maint_reg(maint_reg), .refresh_row_set(refresh_row_set));

    function automatic logic [23:0] cr(input logic [2:0] pop,
        input logic [2:0] pb, input logic [2:0] rop, input logic [7:0] f);
        return {SEL_CLOSE_REFRESH, pop, pb, rop, 3'h0, f};
    endfunction : cr

    // Sends one packet and records every strobe, its cycle and payload
    task automatic run(input logic [23:0] pkt);
        seen = '0;
        dbl = '0;
        fork
            i_req_controller_model.send(pkt);
            for (int c = 0; c < 50; c++) begin
                @(negedge clock);
                for (int k = 0; k < 11; k++) begin
                    if (strb[k] === 1'b1) begin
                        dbl[k] = seen[k];
                        seen[k] = 1'b1;
                        lat[k] = c;
                    end
                end
                if ((|strb[10:8]) === 1'b1) ccap = col_cmd_reg;
                if (row_open_reg === 1'b1) ocap = open_cmd_reg;
                if (bank_close_reg === 1'b1) pcap = close_bank_reg;
                if (refresh_close_reg === 1'b1) fcap = refresh_close_bank_reg;
                if (refresh_open_reg === 1'b1) rcap = refresh_open_cmd_reg;
            end
        join
    endtask : run

    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_strb(input logic [10:0] exp);
        n_tests++;
        if (seen !== exp || dbl !== 11'h000) begin
            error_cnt++;
            $display("MISMATCH strobes expected %h seen %h", exp, seen);
        end
    endtask : chk_strb

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (5) @(negedge clock);
        resetn = 1'b1;
        repeat (4) @(negedge clock);
        chk("row reset", 32'(REFRESH_ROW_RESET), 32'(refresh_row_set));
        run({SEL_IDLE, 20'hfffff});
        chk_strb(11'h000);
        $display("test idle done");
        for (int i = 0; i < 4; i++) begin
            run({SEL_COLUMN, i[1], i[0], 3'h5, 5'h0, 10'h3a7});
            chk_strb(i[1] ? S_WR : S_RD);
            chk("col cmd", {9'h0, 3'h5, 12'h3a7, 8'hff}, 32'(ccap));
            if (i == 0) b = lat[10];
            chk("col delay", b + i[0], lat[i[1] ? 9 : 10]);
        end
        $display("test column done");
        for (int s = 8; s < 16; s += 7) begin
            run({s[3:0], 3'h5, 7'h36, 10'h155});
            chk_strb(S_WM);
            chk("mask cmd", {9'h0, 3'h5, 12'h155, 8'hb6}, 32'(ccap));
        end
        $display("test masked done");
        for (int d = 0; d < 2; d++) begin
            run({4'h4 + 4'(3 * d), 1'b0, d[0], 3'h6, 3'h0, 12'hc3a});
            chk_strb(S_ACT);
            chk("open cmd", {9'h0, 3'h6, 12'hc3a, 8'h00}, 32'(ocap));
            if (d == 0) b = lat[7];
            chk("open delay", b + d, lat[7]);
        end
        $display("test open done");
        for (int p = 0; p < 8; p++) begin
            run(cr(p[2:0], 3'h2, REF_IDLE, 8'hff));
            chk_strb(p[2] ? S_PRE : 11'h000);
            if (p == 4) b = lat[6];
            if (p >= 4) chk("close delay", b + p - 4, lat[6]);
            if (p >= 4) chk("close bank", 32'h2, 32'(pcap));
        end
        $display("test close done");
        run(cr(3'h0, 3'h0, REF_LOAD_LOW, 8'hfe));
        chk("row low", 32'hfe, 32'(refresh_row_set));
        run(cr(3'h0, 3'h0, REF_LOAD_MID, 8'hfa));
        chk("row mid", 32'hafe, 32'(refresh_row_set));
        for (int i = 0; i < 8; i++) begin
            run(cr(3'h0, 3'h0, i[2] ? REF_OPEN : REF_CLOSE,
                {i[1:0], 3'h0, 3'h3}));
            chk_strb(i[2] ? S_ROP : S_RCL);
            if (i[1:0] == 2'b00) b = lat[i[2] ? 4 : 5];
            chk("refresh delay", b + i[1:0], lat[i[2] ? 4 : 5]);
            if (i[2]) chk("ref open", 32'h3afe, 32'(rcap[22:8]));
            else chk("ref close bank", 32'h3, 32'(fcap));
        end
        chk("row kept", 32'hafe, 32'(refresh_row_set));
        $display("test refresh done");
        run(cr(3'h0, 3'h0, REF_OPEN_INC, 8'h84));
        chk_strb(S_ROP);
        chk("inc open", 32'h4afe, 32'(rcap[22:8]));
        chk("inc row", 32'haff, 32'(refresh_row_set));
        run(cr(3'h0, 3'h0, REF_LOAD_LOW, 8'hff));
        run(cr(3'h0, 3'h0, REF_LOAD_MID, 8'h0f));
        run(cr(3'h0, 3'h0, REF_OPEN_INC, 8'h01));
        chk("wrap open", 32'h1fff, 32'(rcap[22:8]));
        chk("wrap row", 32'h000, 32'(refresh_row_set));
        for (int r = 6; r < 8; r++) begin
            run(cr(3'h0, 3'h0, r[2:0], 8'h55));
            chk_strb(11'h000);
            chk("row reserved", 32'h000, 32'(refresh_row_set));
        end
        run(cr(3'h6, 3'h1, REF_CLOSE, 8'h47));
        chk_strb(S_PRE | S_RCL);
        chk("both banks", 32'h0f, {26'h0, pcap, fcap});
        $display("test increment done");
        for (int x = 0; x < 16; x++) begin
            run({SEL_EXTENDED, 16'h0, x[3:0]});
            case (x)
                8: chk_strb(11'h008);
                9: chk_strb(11'h004);
                10: chk_strb(11'h002);
                12: chk_strb(11'h001);
                default: chk_strb(11'h000);
            endcase
        end
        $display("test extended done");
        final_report();
    end
endmodule : test_dram_request_opcode_decoder
